// File: hdl/dbm_codec.sv
`timescale 1ns/1ps
module dbm_codec
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Mode register images
    input  wire logic [dbm_pkg::MODE_W-1:0]    modeRegThree,
    input  wire logic [dbm_pkg::MODE_W-1:0]    modeRegThirteen,
    // Write beats from the pins
    input  wire dbm_pkg::dbm_cmd_t             wrCmd,
    input  wire logic                          wrBeatValid,
    output wire logic                          wrBeatReady,
    input  wire logic [dbm_pkg::DATA_W-1:0]    wrDq,
    input  wire logic [dbm_pkg::LANES-1:0]     wrDmi,
    output logic [dbm_pkg::LANES-1:0]          dmiRxEn,
    output logic                               illegalMaskedWrite,
    // Toward the array
    output wire logic                          arrValid,
    input  wire logic                          arrReady,
    output wire logic [dbm_pkg::DATA_W-1:0]    arrData,
    output wire logic [dbm_pkg::LANES-1:0]     arrByteEn,
    output wire logic                          arrToFifo,
    // Read beats
    input  wire dbm_pkg::dbm_cmd_t             rdCmd,
    input  wire logic                          rdBeatValid,
    input  wire logic [dbm_pkg::DATA_W-1:0]    rdDq,
    input  wire logic [dbm_pkg::LANES-1:0]     calDmi,
    output logic [dbm_pkg::DATA_W-1:0]         dqOut,
    output logic                               dqOe,
    output logic [dbm_pkg::LANES-1:0]          dmiOut,
    output logic [dbm_pkg::LANES-1:0]          dmiOe
);
    localparam int LW = dbm_pkg::LANE_W;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic wrInvEn;
    logic rdInvEn;
    logic maskEn;
    logic anyEn;

    assign wrInvEn = modeRegThree[dbm_pkg::WR_INV_BIT];
    assign rdInvEn = modeRegThree[dbm_pkg::RD_INV_BIT];
    assign maskEn  = !modeRegThirteen[dbm_pkg::MASK_DIS_BIT];
    assign anyEn   = maskEn || wrInvEn || rdInvEn;

    function automatic logic [dbm_pkg::CNT_W-1:0] ones
        (input logic [LW-1:0] b, input int lo);
        logic [dbm_pkg::CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < LW; i++)
            if (i >= lo)
                c = c + dbm_pkg::CNT_W'(b[i]);
        return c;
    endfunction

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    dbm_beat_if bufIn ();
    dbm_beat_if bufOut ();

    logic                          isMaskedWr;
    logic                          dropBeat;
    logic                          wrTake;
    logic [dbm_pkg::DATA_W-1:0]    wrData;
    logic [dbm_pkg::LANES-1:0]     wrEn;

    assign isMaskedWr = wrCmd == dbm_pkg::CMD_MASKED_WRITE;
    // A masked write with masking off is refused and never reaches
    // the array; the controller is not expected to send one
    assign dropBeat = isMaskedWr && !maskEn;
    assign wrTake   = wrBeatValid && bufIn.ready;

    // Every beat and lane is decided from its own inputs only
    genvar g;
    generate
        for (g = 0; g < dbm_pkg::LANES; g++)
        begin : g_wrLane
            logic [LW-1:0] d;
            logic          pin;
            logic          bigUpper;
            assign d   = wrDq[g*LW +: LW];
            assign pin = wrDmi[g];
            assign bigUpper = ones(d, dbm_pkg::UPPER_LO)
                >= dbm_pkg::CNT_W'(dbm_pkg::MASK_LIMIT);
            always_comb
            begin
                wrData[g*LW +: LW] = d;
                wrEn[g]            = 1'b1;
                case (wrCmd)
                    dbm_pkg::CMD_WRITE:
                    begin
                        if (wrInvEn && pin)
                            wrData[g*LW +: LW] = ~d;
                    end
                    dbm_pkg::CMD_MASKED_WRITE:
                    begin
                        if (maskEn && !wrInvEn)
                            wrEn[g] = !pin;
                        else if (maskEn && wrInvEn)
                        begin
                            if (!pin && bigUpper)
                                wrEn[g] = 1'b0;
                            else if (pin)
                                wrData[g*LW +: LW] = ~d;
                        end
                    end
                    default:
                    begin
                        // Training loads and idle pass data as is
                        wrData[g*LW +: LW] = d;
                    end
                endcase
            end
        end
    endgenerate

    assign bufIn.valid  = wrBeatValid && !dropBeat;
    assign bufIn.data   = wrData;
    assign bufIn.byteEn = wrEn;
    assign bufIn.toFifo = wrCmd == dbm_pkg::CMD_WR_FIFO;
    assign wrBeatReady  = bufIn.ready;

    dbm_buffer u_buffer
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .inBeat  (bufIn),
        .outBeat (bufOut)
    );

    assign arrValid     = bufOut.valid;
    assign bufOut.ready = arrReady;
    assign arrData      = bufOut.data;
    assign arrByteEn    = bufOut.byteEn;
    assign arrToFifo    = bufOut.toFifo;

    // ------------------------------------------------------------
    // Receiver enable and refusal flag
    // ------------------------------------------------------------
    logic rxOn;

    always_comb
    begin
        case (wrCmd)
            dbm_pkg::CMD_WRITE,
            dbm_pkg::CMD_MASKED_WRITE: rxOn = maskEn || wrInvEn;
            dbm_pkg::CMD_WR_FIFO:      rxOn = anyEn;
            default:                   rxOn = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dmiRxEn            <= '0;
            illegalMaskedWrite <= 1'b0;
        end
        else
        begin
            dmiRxEn            <= {dbm_pkg::LANES{rxOn}};
            illegalMaskedWrite <= wrBeatValid && dropBeat;
        end
    end

    // ------------------------------------------------------------
    // Training pattern store
    // ------------------------------------------------------------
    logic [dbm_pkg::LANES-1:0]  pat_r [dbm_pkg::PAT_DEPTH];
    logic [dbm_pkg::PAT_AW-1:0] patWr_r;
    logic [dbm_pkg::PAT_AW-1:0] patRd_r;
    logic                       patLoad;
    logic                       patPop;

    assign patLoad = wrTake && wrCmd == dbm_pkg::CMD_WR_FIFO && anyEn;
    assign patPop  = rdBeatValid && rdCmd == dbm_pkg::CMD_RD_FIFO;

    // Pointers wrap; an overrun silently reuses the oldest entry
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            patWr_r <= '0;
            patRd_r <= '0;
        end
        else
        begin
            if (patLoad)
                patWr_r <= patWr_r + 3'h1;
            if (patPop)
                patRd_r <= patRd_r + 3'h1;
        end
    end

    generate
        for (g = 0; g < dbm_pkg::PAT_DEPTH; g++)
        begin : g_pat
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    pat_r[g] <= '0;
                else if (patLoad && patWr_r == dbm_pkg::PAT_AW'(g))
                    pat_r[g] <= wrDmi;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [dbm_pkg::DATA_W-1:0] rdData;
    logic [dbm_pkg::LANES-1:0]  rdFlag;
    logic [dbm_pkg::LANES-1:0]  rdFlagOe;

    generate
        for (g = 0; g < dbm_pkg::LANES; g++)
        begin : g_rdLane
            logic [LW-1:0] d;
            logic          heavy;
            assign d     = rdDq[g*LW +: LW];
            assign heavy = ones(d, 0)
                > dbm_pkg::CNT_W'(dbm_pkg::INV_LIMIT);
            always_comb
            begin
                rdData[g*LW +: LW] = d;
                rdFlag[g]          = 1'b0;
                rdFlagOe[g]        = 1'b0;
                case (rdCmd)
                    dbm_pkg::CMD_READ:
                    begin
                        rdFlagOe[g] = rdInvEn;
                        if (rdInvEn && heavy)
                        begin
                            rdData[g*LW +: LW] = ~d;
                            rdFlag[g]          = 1'b1;
                        end
                    end
                    dbm_pkg::CMD_MODE_READ:
                    begin
                        rdFlagOe[g] = rdInvEn;
                    end
                    dbm_pkg::CMD_RD_FIFO:
                    begin
                        rdFlagOe[g] = anyEn;
                        rdFlag[g]   = pat_r[patRd_r][g];
                    end
                    dbm_pkg::CMD_RD_TRAIN:
                    begin
                        rdFlagOe[g] = anyEn;
                        rdFlag[g]   = calDmi[g];
                    end
                    default:
                    begin
                        rdFlagOe[g] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // Pin and data leave together on the same beat
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dqOut  <= '0;
            dqOe   <= 1'b0;
            dmiOut <= '0;
            dmiOe  <= '0;
        end
        else if (rdBeatValid)
        begin
            dqOut  <= rdData;
            dqOe   <= 1'b1;
            dmiOut <= rdFlag & rdFlagOe;
            dmiOe  <= rdFlagOe;
        end
        else
        begin
            dqOut  <= '0;
            dqOe   <= 1'b0;
            dmiOut <= '0;
            dmiOe  <= '0;
        end
    end

endmodule // dbm_codec

// File: pkg/dbm_pkg.sv
// Contract
// - Masking on writes only; inversion both ways, per lane
// - Write inversion enabled by mode bit seven high
// - Read inversion has its own mode bit
// - Mask disable bit: zero enables, one disables
// - One mask/invert pin per byte lane, two lanes
// - Pin travels beat for beat with data lines
// - All write functions off: pin ignored, receiver off
// - Read inversion off: driver off; all off likewise
// - Write inversion: pin high inverts received byte
// - Read: more than four ones inverts, pin high
// - Masked write, no inversion: pin high masks byte
// - Both on: pin low and five upper ones masks
// - Write FIFO load stores pin as pattern only
// - Read FIFO drives back stored pin pattern
// - Read training drives calibration pattern on pin
// - Mode readback never inverts; pin held low
package dbm_pkg;

    localparam int LANES       = 2;
    localparam int LANE_W      = 8;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int MODE_W      = 8;
    localparam int WR_INV_BIT  = 7;
    localparam int RD_INV_BIT  = 6;
    localparam int MASK_DIS_BIT = 5;
    localparam int INV_LIMIT   = 4;
    localparam int MASK_LIMIT  = 5;
    localparam int UPPER_LO    = 2;
    localparam int CNT_W       = 4;
    localparam int PAT_DEPTH   = 8;
    localparam int PAT_AW      = 3;
    localparam int BUF_DEPTH   = 2;
    localparam int BUF_CW      = 2;

    typedef enum logic [2:0] {
        CMD_IDLE,
        CMD_WRITE,
        CMD_MASKED_WRITE,
        CMD_WR_FIFO,
        CMD_READ,
        CMD_RD_FIFO,
        CMD_RD_TRAIN,
        CMD_MODE_READ
    } dbm_cmd_t;

endpackage

// File: pkg/dbm_beat_if.sv
`timescale 1ns/1ps
interface dbm_beat_if;
    logic                        valid;
    logic                        ready;
    logic [dbm_pkg::DATA_W-1:0]  data;
    logic [dbm_pkg::LANES-1:0]   byteEn;
    logic                        toFifo;

    modport src (output valid, data, byteEn, toFifo, input ready);
    modport snk (input valid, data, byteEn, toFifo, output ready);
endinterface

// File: hdl/dbm_buffer.sv
`timescale 1ns/1ps
module dbm_buffer
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    dbm_beat_if.snk    inBeat,
    dbm_beat_if.src    outBeat
);
    localparam int EW = dbm_pkg::DATA_W + dbm_pkg::LANES + 1;

    logic [EW-1:0]              slot_r [dbm_pkg::BUF_DEPTH];
    logic [dbm_pkg::BUF_CW-1:0] count_r;
    logic [dbm_pkg::BUF_CW-1:0] countNxt;
    logic                       ready_r;
    logic                       valid_r;
    logic                       push;
    logic                       pop;
    logic [EW-1:0]              inWord;

    assign push   = inBeat.valid && ready_r;
    assign pop    = valid_r && outBeat.ready;
    assign inWord = {inBeat.toFifo, inBeat.byteEn, inBeat.data};

    always_comb
    begin
        countNxt = count_r;
        if (push && !pop)
            countNxt = count_r + 2'h1;
        else if (pop && !push)
            countNxt = count_r - 2'h1;
    end

    // Ready is registered so a stalled array holds the source off cleanly
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= 2'h0;
            ready_r <= 1'b1;
            valid_r <= 1'b0;
        end
        else
        begin
            count_r <= countNxt;
            ready_r <= countNxt != 2'(dbm_pkg::BUF_DEPTH);
            valid_r <= countNxt != 2'h0;
        end
    end

    // Head always sits in slot 0; a pop shifts slot 1 forward
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_r[0] <= '0;
            slot_r[1] <= '0;
        end
        else
        begin
            if (pop)
                slot_r[0] <= (count_r == 2'h2) ? slot_r[1] : inWord;
            else if (push && count_r == 2'h0)
                slot_r[0] <= inWord;
            if (push && (count_r - 2'(pop)) == 2'h1)
                slot_r[1] <= inWord;
        end
    end

    assign inBeat.ready   = ready_r;
    assign outBeat.valid  = valid_r;
    assign outBeat.data   = slot_r[0][dbm_pkg::DATA_W-1:0];
    assign outBeat.byteEn =
        slot_r[0][dbm_pkg::DATA_W +: dbm_pkg::LANES];
    assign outBeat.toFifo = slot_r[0][EW-1];

endmodule // dbm_buffer

// File: testbench/dbm_codec_assertions.sv
`timescale 1ns/1ps
// ----------
// Pin checks
// ----------
module dbm_codec_assertions
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [7:0]        modeRegThree,
    input wire logic [7:0]        modeRegThirteen,
    input wire dbm_pkg::dbm_cmd_t wrCmd,
    input wire logic              wrBeatValid,
    input wire logic              wrBeatReady,
    input wire logic [15:0]       wrDq,
    input wire logic [1:0]        dmiRxEn,
    input wire logic              illegalMaskedWrite,
    input wire logic              arrValid,
    input wire logic [15:0]       arrData,
    input wire logic [1:0]        arrByteEn,
    input wire dbm_pkg::dbm_cmd_t rdCmd,
    input wire logic              rdBeatValid,
    input wire logic [15:0]       rdDq,
    input wire logic [1:0]        calDmi,
    input wire logic [15:0]       dqOut,
    input wire logic [1:0]        dmiOut,
    input wire logic [1:0]        dmiOe
);
    wire rInv = modeRegThree[6];
    wire wOff = modeRegThirteen[5] & ~modeRegThree[7];
    wire isRd = rdBeatValid && rdCmd == dbm_pkg::CMD_READ;
    wire isMr = rdBeatValid && rdCmd == dbm_pkg::CMD_MODE_READ;
    wire wrGo = wrBeatValid && wrBeatReady;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_rx_off: assert property (
        wOff && (wrCmd == dbm_pkg::CMD_WRITE
        || wrCmd == dbm_pkg::CMD_MASKED_WRITE
        || (wrCmd == dbm_pkg::CMD_WR_FIFO && !rInv))
        |=> dmiRxEn == 2'h0) else $error("receiver on");
    chk_drv_off: assert property (
        rdBeatValid && !rInv && (wOff || rdCmd == dbm_pkg::CMD_READ
        || rdCmd == dbm_pkg::CMD_MODE_READ) |=> dmiOe == 2'h0)
        else $error("driver on");
    chk_inv_flag: assert property (
        isRd && rInv |=> dmiOe == 2'h3
        && dmiOut == {$countones($past(rdDq[15:8])) > 4,
        $countones($past(rdDq[7:0])) > 4}) else $error("bad flag");
    chk_inv_data: assert property (
        isRd && rInv |=>
        dqOut == ($past(rdDq) ^ {{8{dmiOut[1]}}, {8{dmiOut[0]}}}))
        else $error("bad read data");
    chk_mrr_low: assert property (
        isMr && rInv |=> dmiOe == 2'h3 && dmiOut == 2'h0
        && dqOut == $past(rdDq)) else $error("readback pin");
    chk_train_pin: assert property (
        rdBeatValid && !(wOff && !rInv) && rdCmd == dbm_pkg::CMD_RD_TRAIN
        |=> dmiOe == 2'h3 && dmiOut == $past(calDmi))
        else $error("bad pattern");
    chk_pin_quiet: assert property (
        (dmiOut & ~dmiOe) == 2'h0) else $error("pin data while off");
    chk_illegal_mw: assert property (
        wrGo && modeRegThirteen[5] && wrCmd == dbm_pkg::CMD_MASKED_WRITE
        |=> illegalMaskedWrite) else $error("no illegal pulse");
    chk_plain_write: assert property (
        wrGo && !arrValid && !modeRegThree[7] && wrCmd == dbm_pkg::CMD_WRITE
        |=> arrValid && arrByteEn == 2'h3 && arrData == $past(wrDq))
        else $error("plain write altered");
    chk_rx_on: assert property (
        (!wOff && (wrCmd == dbm_pkg::CMD_WRITE
        || wrCmd == dbm_pkg::CMD_MASKED_WRITE))
        || (wrCmd == dbm_pkg::CMD_WR_FIFO && !(wOff && !rInv))
        |=> dmiRxEn == 2'h3) else $error("receiver off");
endmodule // dbm_codec_assertions

bind dbm_codec dbm_codec_assertions dbm_codec_assertions_inst (.clk,
    .rst_n, .modeRegThree, .modeRegThirteen, .wrCmd, .wrBeatValid,
    .wrBeatReady, .wrDq, .dmiRxEn, .illegalMaskedWrite, .arrValid,
    .arrData, .arrByteEn, .rdCmd, .rdBeatValid, .rdDq, .calDmi, .dqOut,
    .dmiOut, .dmiOe);

// File: testbench/dbm_ctrl_model.sv
`timescale 1ns/1ps
// ----------------
// Controller model
// ----------------
module dbm_ctrl_model
(
    input  wire logic         clk,
    input  wire logic         wrBeatReady,
    output dbm_pkg::dbm_cmd_t wrCmd,
    output logic              wrBeatValid,
    output logic [15:0]       wrDq,
    output logic [1:0]        wrDmi,
    output dbm_pkg::dbm_cmd_t rdCmd,
    output logic              rdBeatValid,
    output logic [15:0]       rdDq,
    output logic [1:0]        calDmi
);
    initial
    begin
        wrCmd = dbm_pkg::CMD_IDLE;
        rdCmd = dbm_pkg::CMD_IDLE;
        wrBeatValid = 1'b0;
        rdBeatValid = 1'b0;
        wrDq = 16'h0000;
        wrDmi = 2'h0;
        rdDq = 16'h0000;
        calDmi = 2'h0;
    end

    task automatic wrBeat(input dbm_pkg::dbm_cmd_t c,
        input logic [15:0] d, input logic [1:0] m);
        wrCmd = c;
        wrDq = d;
        wrDmi = m;
        wrBeatValid = 1'b1;
        do
            @(posedge clk);
        while (wrBeatReady !== 1'b1);
        #1;
    endtask

    task automatic rdBeat(input dbm_pkg::dbm_cmd_t c,
        input logic [15:0] d, input logic [1:0] cal);
        rdCmd = c;
        rdDq = d;
        calDmi = cal;
        rdBeatValid = 1'b1;
        @(posedge clk);
        #1;
    endtask

    // Released lines flip so a stale value can never look valid
    task automatic idle();
        wrBeatValid = 1'b0;
        rdBeatValid = 1'b0;
        wrCmd = dbm_pkg::CMD_IDLE;
        rdCmd = dbm_pkg::CMD_IDLE;
        wrDq = ~wrDq;
        wrDmi = ~wrDmi;
        rdDq = ~rdDq;
        calDmi = ~calDmi;
        @(posedge clk);
        #1;
    endtask
endmodule // dbm_ctrl_model

// File: testbench/dram_byte_mask_inversion_tb.sv
`timescale 1ns/1ps
// -----------
// Codec bench
// -----------
module dram_byte_mask_inversion_tb;
    logic              clk, rst_n, wrBeatValid, wrBeatReady, arrValid;
    logic              arrToFifo, illegalMaskedWrite, rdBeatValid, dqOe;
    logic              rdPend, maskEn, wInv, rInv, anyOn;
    logic              arrReady = 1'b0;
    logic              stall = 1'b0;
    logic [7:0]        modeRegThree, modeRegThirteen;
    logic [15:0]       wrDq, arrData, rdDq, dqOut, lm;
    logic [1:0]        wrDmi, dmiRxEn, arrByteEn, calDmi, dmiOut, dmiOe;
    logic [1:0]        pat [8];
    logic [2:0]        wp, rp;
    logic [18:0]       we, wq [$];
    logic [20:0]       re, rq [$];
    dbm_pkg::dbm_cmd_t wrCmd, rdCmd;
    int                errCount, testsRun, illExp, illSeen;
    int                seed = 6;

    dbm_codec dbm_codec_inst (.clk, .rst_n, .modeRegThree, .modeRegThirteen,
        .wrCmd, .wrBeatValid, .wrBeatReady, .wrDq, .wrDmi, .dmiRxEn,
        .illegalMaskedWrite, .arrValid, .arrReady, .arrData, .arrByteEn,
        .arrToFifo, .rdCmd, .rdBeatValid, .rdDq, .calDmi, .dqOut, .dqOe,
        .dmiOut, .dmiOe);
    dbm_ctrl_model dbm_ctrl_model_inst (.clk, .wrBeatReady, .wrCmd,
        .wrBeatValid, .wrDq, .wrDmi, .rdCmd, .rdBeatValid, .rdDq, .calDmi);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        #1;
        arrReady = !stall && ($random(seed) & 3) != 0;
    end

    task automatic cmpBeat(input logic [18:0] e, input logic [18:0] g);
        testsRun++;
        if (g !== e)
        begin
            errCount++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmpPin(input logic [20:0] e, input logic [20:0] g);
        testsRun++;
        if (g !== e)
        begin
            errCount++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // Data of a masked lane is free, so it is cleared on both sides
    always @(posedge clk)
    begin
        if (arrValid === 1'b1 && arrReady === 1'b1)
        begin
            we = (wq.size() > 0) ? wq.pop_front() : 19'h7ffff;
            lm = {{8{we[17]}}, {8{we[16]}}};
            cmpBeat(we & {3'h7, lm},
                {arrToFifo, arrByteEn, arrData & lm});
        end
        if (rdPend === 1'b1)
        begin
            re = (rq.size() > 0) ? rq.pop_front() : 21'h1fffff;
            cmpPin(re, {re[20] & dqOe, dmiOe, dmiOut,
                re[20] ? dqOut : re[15:0]});
        end
        if (illegalMaskedWrite === 1'b1)
            illSeen++;
        rdPend <= rdBeatValid;
    end

    task automatic drain();
        int n;
        dbm_ctrl_model_inst.idle();
        n = 0;
        while ((wq.size() > 0 || arrValid !== 1'b0) && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic sendWr(input dbm_pkg::dbm_cmd_t c, input int n);
        logic [15:0] d, o;
        logic [1:0]  m, be;
        logic [7:0]  b;
        if (c == dbm_pkg::CMD_MASKED_WRITE && !maskEn)
            drain();
        repeat (n)
        begin
            d = 16'($random(seed));
            m = 2'($random(seed));
            if (c == dbm_pkg::CMD_WRITE && maskEn && !wInv)
                m = 2'h0;
            o = d;
            be = 2'h3;
            for (int i = 0; i < 2; i++)
            begin
                b = d[8*i+:8];
                if (c == dbm_pkg::CMD_MASKED_WRITE
                    && (wInv ? !m[i] && $countones(b[7:2]) >= 5 : m[i]))
                    be[i] = 1'b0;
                else if (c != dbm_pkg::CMD_WR_FIFO && wInv && m[i])
                    o[8*i+:8] = ~b;
            end
            if (c == dbm_pkg::CMD_WR_FIFO && anyOn)
            begin
                pat[wp] = m;
                wp++;
            end
            if (c == dbm_pkg::CMD_MASKED_WRITE && !maskEn)
                illExp++;
            else
                wq.push_back({c == dbm_pkg::CMD_WR_FIFO, be, o});
            dbm_ctrl_model_inst.wrBeat(c, d, m);
        end
    endtask

    task automatic sendRd(input dbm_pkg::dbm_cmd_t c);
        logic [15:0] d, q;
        logic [1:0]  cal, oe, out;
        logic        plain;
        repeat (8)
        begin
            d = 16'($random(seed));
            cal = 2'($random(seed));
            q = d;
            out = 2'h0;
            plain = c == dbm_pkg::CMD_READ || c == dbm_pkg::CMD_MODE_READ;
            oe = {2{plain ? rInv : anyOn}};
            if (c == dbm_pkg::CMD_RD_FIFO)
            begin
                out = pat[rp];
                rp++;
            end
            if (c == dbm_pkg::CMD_RD_TRAIN)
                out = oe & cal;
            for (int i = 0; i < 2; i++)
                if (c == dbm_pkg::CMD_READ && rInv
                    && $countones(d[8*i+:8]) > 4)
                begin
                    out[i] = 1'b1;
                    q[8*i+:8] = ~d[8*i+:8];
                end
            rq.push_back({plain, oe, out, q});
            dbm_ctrl_model_inst.rdBeat(c, d, cal);
        end
    endtask

    task automatic tallyAndFinish();
        $display("Compares %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'b0;
        rdPend = 1'b0;
        wp = 3'h0;
        rp = 3'h0;
        modeRegThree = 8'h00;
        modeRegThirteen = 8'h20;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int md = 0; md < 8; md++)
        begin
            {maskEn, wInv, rInv} = 3'(md);
            anyOn = maskEn | wInv | rInv;
            modeRegThree = {wInv, rInv, 6'h00};
            modeRegThirteen = {2'h0, !maskEn, 5'h00};
            @(posedge clk);
            #1;
            sendWr(dbm_pkg::CMD_WRITE, 16);
            sendWr(dbm_pkg::CMD_MASKED_WRITE, 16);
            sendWr(dbm_pkg::CMD_WR_FIFO, 8);
            drain();
            // Only the load pointer needs some function on; a FIFO read always moves the read pointer
            for (int k = 4; k < 8; k++)
                if (anyOn || k != 5)
                    sendRd(dbm_pkg::dbm_cmd_t'(3'(k)));
            drain();
        end
        stall = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sendWr(dbm_pkg::CMD_WRITE, 2);
        dbm_ctrl_model_inst.idle();
        cmpPin(21'h0, {20'h0, wrBeatReady});
        stall = 1'b0;
        drain();
        cmpPin(21'(illExp), 21'(illSeen));
        tallyAndFinish();
    end

    // The run needs about a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errCount++;
        tallyAndFinish();
    end
endmodule // dram_byte_mask_inversion_tb
